// [dv/apgd_pad_model.sv]
// Outside parts wired to the audio port pins: pad resolution and serial bit clocks
`timescale 1ns/1ps
module apgd_pad_model (
  input  wire logic        clk,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_val,
  input  wire logic        tx_run,
  input  wire logic        rx_run,
  output logic      [31:0] pin_level
);
  logic [1:0]  div_q;     // Bit clock divider
  logic        bclk_q;    // Bit clock level shared by both directions
  logic [31:0] far_drive; // What the outside parts put on each pad

  // Start from a known divider state
  initial begin
    div_q  = 2'h0;
    bclk_q = 1'b0;
  end

  // Bit clock at one eighth of the system clock
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      bclk_q <= ~bclk_q;
    end
  end

  // Stopped clocks stand still at the plain outside level
  always_comb begin
    far_drive = ext_val;
    if (tx_run) begin
      far_drive[apgd_pkg::TXCLK_BIT] = bclk_q;
    end
    if (rx_run) begin
      far_drive[apgd_pkg::RXCLK_BIT] = bclk_q;
    end
    // Device wins the pad wherever it drives
    pin_level = (pin_oe & pin_out) | (~pin_oe & far_drive);
  end
endmodule : apgd_pad_model

// [dv/testbench.sv]
// Self-checking bench for the audio port pin GPIO data block
`timescale 1ns/1ps
module testbench;
  logic        clk;         // System clock
  logic        srst;        // Synchronous reset
  logic [7:0]  reg_addr;    // Register address
  logic [31:0] reg_wdata;   // Write data
  logic        reg_wr;      // Write strobe
  logic        reg_rd;      // Read strobe
  logic [31:0] reg_rdata;   // Read data
  logic [31:0] pin_in;      // Resolved pad levels
  logic [31:0] pin_out;     // Device drive level
  logic [31:0] pin_oe;      // Device drive enable
  logic [31:0] port_out;    // Serial core drive level
  logic [4:0]  tx_init;     // Latched transmit half
  logic [4:0]  rx_init;     // Latched receive half
  logic [31:0] ext_val;     // Level the outside parts drive
  logic        tx_run;      // Transmit bit clock running
  logic        rx_run;      // Receive bit clock running
  logic [31:0] exp_q[$];    // Expected read data, oldest first
  logic        rd_seen;     // Read strobe taken at last edge
  logic [31:0] out_m;       // Model of the output data
  logic [31:0] f;           // Function select written
  logic [31:0] d;           // Direction written
  logic [31:0] po;          // Expected pad drive level
  int          num_errors;  // Mismatch count
  int          check_count; // Comparison count
  int          cycles;      // Timeout counter

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  apgd_gpio_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_out(port_out), .tx_init(tx_init), .rx_init(rx_init));

  apgd_pad_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .tx_run(tx_run),
    .rx_run(rx_run), .pin_level(pin_in));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // One-cycle write
  task automatic reg_write(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // One-cycle read; the monitor judges the answer
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    exp_q.push_back(exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : reg_read

  // Let registered outputs and the pin synchroniser land
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  // Wait for both init halves, bounded
  task automatic wait_init(input logic [4:0] tx_exp, input logic [4:0] rx_exp);
    for (int i = 0; i < 100 && !(tx_init === tx_exp && rx_init === rx_exp); i++) begin
      @(posedge clk);
    end
    #1;
  endtask : wait_init

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("MISMATCH t=%0t read data without expectation", $time);
      end else begin
        check(reg_rdata, exp_q.pop_front());
      end
    end
    rd_seen <= reg_rd;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    port_out = 32'h0;
    ext_val = 32'h0;
    tx_run = 1'b0;
    rx_run = 1'b0;
    rd_seen = 1'b0;
    out_m = 32'h0;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    void'($urandom(32'hD03C));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Reset values, unmapped place at 0x1C included
    for (int i = 0; i < 8; i++) begin
      reg_read(8'(i * 4), 32'h0);
    end
    settle();
    check(pin_out, 32'h0);
    check(pin_oe, 32'h0);
    $display("test reset done");
    // Random function, direction, data, set and clear, reserved bits written as zero
    for (int k = 0; k < 8; k++) begin
      f = $urandom & apgd_pkg::PIN_MASK;
      d = $urandom & apgd_pkg::PIN_MASK;
      po = $urandom & apgd_pkg::PIN_MASK;
      reg_write(apgd_pkg::OFS_FUNC, f);
      reg_write(apgd_pkg::OFS_DIR, d);
      reg_write(apgd_pkg::OFS_OUT, po);
      out_m = po & apgd_pkg::PIN_MASK;
      po = $urandom & apgd_pkg::PIN_MASK;
      reg_write(apgd_pkg::OFS_SET, po);
      out_m = (out_m | po) & apgd_pkg::PIN_MASK;
      po = $urandom & apgd_pkg::PIN_MASK;
      reg_write(apgd_pkg::OFS_CLR, po);
      out_m = out_m & ~po;
      f = f & apgd_pkg::PIN_MASK;
      d = d & apgd_pkg::PIN_MASK;
      port_out <= $urandom;
      ext_val <= $urandom;
      settle();
      po = ((f & out_m) | (~f & port_out)) & apgd_pkg::PIN_MASK;
      check(pin_out, po);
      check(pin_oe, d);
      reg_read(apgd_pkg::OFS_OUT, out_m);
      reg_read(apgd_pkg::OFS_FUNC, f);
      reg_read(apgd_pkg::OFS_DIR, d);
      reg_read(apgd_pkg::OFS_LEVEL, ((d & po) | (~d & ext_val)) & apgd_pkg::PIN_MASK);
      reg_read(apgd_pkg::OFS_SET, 32'h0);
      reg_read(apgd_pkg::OFS_CLR, 32'h0);
    end
    $display("test random pins done");
    // Walking set then walking clear on every bit position
    reg_write(apgd_pkg::OFS_FUNC, apgd_pkg::PIN_MASK);
    reg_write(apgd_pkg::OFS_DIR, apgd_pkg::PIN_MASK);
    reg_write(apgd_pkg::OFS_OUT, 32'h0);
    out_m = 32'h0;
    for (int i = 0; i < 64; i++) begin
      if (i < 32) begin
        reg_write(apgd_pkg::OFS_SET, 32'h1 << i);
        out_m = (out_m | (32'h1 << i)) & apgd_pkg::PIN_MASK;
      end else begin
        reg_write(apgd_pkg::OFS_CLR, 32'h1 << (i - 32));
        out_m = out_m & ~(32'h1 << (i - 32));
      end
      settle();
      check(pin_out, out_m);
    end
    $display("test walking bits done");
    // Mid-run reset returns the control words to zero
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    reg_read(apgd_pkg::OFS_OUT, 32'h0);
    reg_read(apgd_pkg::OFS_DIR, 32'h0);
    settle();
    check(pin_oe, 32'h0);
    check(pin_out, port_out & apgd_pkg::PIN_MASK);
    check(32'(tx_init), 32'h0);
    $display("test mid reset done");
    // Init latching: clock pins as inputs, clocks running first
    // Quiet outside levels, so a stopped clock pin rests low
    ext_val <= 32'h0;
    reg_write(apgd_pkg::OFS_DIR, 32'h0);
    reg_write(apgd_pkg::OFS_FUNC, 32'h0);
    tx_run <= 1'b1;
    rx_run <= 1'b1;
    reg_write(apgd_pkg::OFS_GINIT, 32'hFFFFFFFF);
    wait_init(5'h1F, 5'h1F);
    check(32'(tx_init), 32'h1F);
    check(32'(rx_init), 32'h1F);
    reg_read(apgd_pkg::OFS_GINIT, 32'h00001F1F);
    // Receive clock stopped: only the transmit half moves
    rx_run <= 1'b0;
    reg_write(apgd_pkg::OFS_GINIT, 32'h00000A05);
    wait_init(5'h0A, 5'h1F);
    repeat (40) @(posedge clk);
    #1;
    check(32'(tx_init), 32'h0A);
    check(32'(rx_init), 32'h1F);
    reg_read(apgd_pkg::OFS_GINIT, 32'h00000A1F);
    // Both clocks stopped: a new request never latches
    tx_run <= 1'b0;
    repeat (8) @(posedge clk);
    reg_write(apgd_pkg::OFS_GINIT, 32'h00000000);
    repeat (20) @(posedge clk);
    #1;
    check(32'(tx_init), 32'h0A);
    check(32'(rx_init), 32'h1F);
    reg_read(apgd_pkg::OFS_GINIT, 32'h00000A1F);
    $display("test init latching done");
    repeat (4) @(posedge clk);
    check(32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule : testbench

// [rtl/apgd_clk_latch.sv]
// Holds a requested control half and latches it on the serial bit clock
`timescale 1ns/1ps
module apgd_clk_latch #(
  parameter int unsigned W = 5
) (
  input  wire logic clk,
  input  wire logic srst,
  apgd_latch_if.lat lif
);
  logic         bclk_prev_q;   // Bit clock level one cycle ago
  logic [W-1:0] pend_q;        // Value written, not yet latched
  logic [W-1:0] lat_q;         // Value seen by the serial section
  logic         bclk_rise;     // Rising edge of the bit clock

  // Refuse a width the carrier cannot hold
  if (W < 1 || W > 32) begin : g_chk
    $error("apgd_clk_latch: width out of range");
  end

  // Edge detect on the already synchronised level
  always_ff @(posedge clk) begin
    if (srst) begin
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_prev_q <= lif.bclk;
    end
  end

  assign bclk_rise = lif.bclk & ~bclk_prev_q;

  // Software request, kept until the clock takes it
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= '0;
    end else if (lif.wr) begin
      pend_q <= lif.wdata;
    end
  end

  // Stopped bit clock means nothing is ever latched
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_q <= '0;
    end else if (bclk_rise) begin
      lat_q <= pend_q;
    end
  end

  assign lif.latched = lat_q;

  latch_edge_a: assert property (@(posedge clk) disable iff (srst)
    (lif.bclk && !bclk_prev_q) |=> (lat_q == $past(pend_q)))
    else $error("latch missed bit clock edge");

  latch_hold_a: assert property (@(posedge clk) disable iff (srst)
    !(lif.bclk && !bclk_prev_q) |=> $stable(lat_q))
    else $error("latched value moved without bit clock");
endmodule : apgd_clk_latch

// [rtl/apgd_gpio_top.sv]
// Pin GPIO data path and global initialization latching for the audio port
// How it works
// - Level register reads live pin levels always
// - Bits 15-0 data, 31-25 frame/clock/mute pins
// - Level readback after reset follows the pins
// - Reserved bits 24-16 read zero, ignore writes
// - Set and clear are storage-free write aliases
// - Set alias ones set output bits
// - Set bit n acts on output bit n
// - Set bit drives GPIO output pin high
// - Clear alias ones clear output bits
// - Clear bit n acts on output bit n
// - Clear bit drives GPIO output pin low
// - Init halves latch on their bit clocks
// - Output bit reaches pin only if GPIO output
// - Output readback is stored data, not pins
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module apgd_gpio_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  input  wire logic [31:0] port_out,
  output logic      [4:0]  tx_init,
  output logic      [4:0]  rx_init
);

  // Address match, used by the write decode of every writable register
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  // Control words
  logic [31:0] out_data_q;     // The single set of output-data bits
  logic [31:0] func_sel_q;     // One selects GPIO function
  logic [31:0] dir_sel_q;      // One selects output
  logic [31:0] rdata_q;        // Read data, valid the cycle after a read

  // Pin synchroniser; first stage read only by the second
  logic [31:0] pin_meta_q;     // First stage
  logic [31:0] pin_sync_q;     // Second stage, safe to read

  // Registered pin drive
  logic [31:0] pin_out_q;      // Level driven on each pin
  logic [31:0] pin_oe_q;       // Drive enable of each pin

  // Decoded writes
  logic        wr_out;         // Direct write of output data
  logic        wr_set;         // Write to the set alias
  logic        wr_clr;         // Write to the clear alias
  logic        wr_func;        // Write to function select
  logic        wr_dir;         // Write to direction select
  logic        wr_ginit;       // Write to global initialization
  logic [31:0] wdata_m;        // Write data with reserved bits dropped

  // Serial-clock latches for the two init halves
  apgd_latch_if #(.W(apgd_pkg::INIT_W)) tx_lif ();
  apgd_latch_if #(.W(apgd_pkg::INIT_W)) rx_lif ();

  // Write decode
  assign wr_out   = reg_wr & addr_hit(reg_addr, apgd_pkg::OFS_OUT);
  assign wr_set   = reg_wr & addr_hit(reg_addr, apgd_pkg::OFS_SET);
  assign wr_clr   = reg_wr & addr_hit(reg_addr, apgd_pkg::OFS_CLR);
  assign wr_func  = reg_wr & addr_hit(reg_addr, apgd_pkg::OFS_FUNC);
  assign wr_dir   = reg_wr & addr_hit(reg_addr, apgd_pkg::OFS_DIR);
  assign wr_ginit = reg_wr & addr_hit(reg_addr, apgd_pkg::OFS_GINIT);

  // Reserved positions never store; stray ones are harmless here
  assign wdata_m  = reg_wdata & apgd_pkg::PIN_MASK;

  // Two-stage synchroniser on every pin input
  // Not reset: the level view has no fixed value after reset anyway
  always_ff @(posedge clk) begin
    pin_meta_q <= pin_in;
    pin_sync_q <= pin_meta_q;
  end

  // Output-data register; the aliases only modify it
  always_ff @(posedge clk) begin
    if (srst) begin
      out_data_q <= apgd_pkg::PIN_RESET;
    end else if (wr_out) begin
      out_data_q <= wdata_m;
    end else if (wr_set) begin
      out_data_q <= out_data_q | wdata_m;
    end else if (wr_clr) begin
      out_data_q <= out_data_q & ~wdata_m;
    end
  end

  // Function select; never touches output data
  always_ff @(posedge clk) begin
    if (srst) begin
      func_sel_q <= apgd_pkg::PIN_RESET;
    end else if (wr_func) begin
      func_sel_q <= wdata_m;
    end
  end

  // Direction select; never touches output data
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_sel_q <= apgd_pkg::PIN_RESET;
    end else if (wr_dir) begin
      dir_sel_q <= wdata_m;
    end
  end

  // Pin drive: GPIO bits take stored data, others the port core
  // One cycle of latency keeps the pins glitch free
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out_q <= apgd_pkg::PIN_RESET;
      pin_oe_q  <= apgd_pkg::PIN_RESET;
    end else begin
      pin_out_q <= apgd_pkg::PIN_MASK & ((func_sel_q & out_data_q) | (~func_sel_q & port_out));
      pin_oe_q  <= apgd_pkg::PIN_MASK & dir_sel_q;
    end
  end

  // Connect the transmit half, clocked by the transmit bit clock pin
  assign tx_lif.wr    = wr_ginit;
  assign tx_lif.wdata = reg_wdata[apgd_pkg::TX_INIT_LSB +: apgd_pkg::INIT_W];
  assign tx_lif.bclk  = pin_sync_q[apgd_pkg::TXCLK_BIT];

  // Connect the receive half, clocked by the receive bit clock pin
  assign rx_lif.wr    = wr_ginit;
  assign rx_lif.wdata = reg_wdata[apgd_pkg::RX_INIT_LSB +: apgd_pkg::INIT_W];
  assign rx_lif.bclk  = pin_sync_q[apgd_pkg::RXCLK_BIT];

  // Transmit latch
  apgd_clk_latch #(.W(apgd_pkg::INIT_W)) u_tx_latch (
    .clk  (clk),
    .srst (srst),
    .lif  (tx_lif)
  );

  // Receive latch
  apgd_clk_latch #(.W(apgd_pkg::INIT_W)) u_rx_latch (
    .clk  (clk),
    .srst (srst),
    .lif  (rx_lif)
  );

  // Read mux; answers zero outside a read and on unmapped offsets
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        apgd_pkg::OFS_OUT:   rdata_q <= out_data_q;
        apgd_pkg::OFS_FUNC:  rdata_q <= func_sel_q;
        apgd_pkg::OFS_DIR:   rdata_q <= dir_sel_q;
        // Live levels, whatever function or direction says
        apgd_pkg::OFS_LEVEL: rdata_q <= pin_sync_q & apgd_pkg::PIN_MASK;
        // Aliases hold nothing to read back
        apgd_pkg::OFS_SET:   rdata_q <= 32'h00000000;
        apgd_pkg::OFS_CLR:   rdata_q <= 32'h00000000;
        // Software polls this until its bits appear
        apgd_pkg::OFS_GINIT: rdata_q <= (32'(tx_lif.latched) << apgd_pkg::TX_INIT_LSB)
                                      | (32'(rx_lif.latched) << apgd_pkg::RX_INIT_LSB);
        default:             rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign pin_out   = pin_out_q;
  assign pin_oe    = pin_oe_q;
  assign tx_init   = tx_lif.latched;
  assign rx_init   = rx_lif.latched;

  // Request shapes seen on the register port
  sequence rd_level_s;
    reg_rd && reg_addr == apgd_pkg::OFS_LEVEL;
  endsequence

  sequence rd_alias_s;
    reg_rd && (reg_addr == apgd_pkg::OFS_SET || reg_addr == apgd_pkg::OFS_CLR);
  endsequence

  sequence rd_ginit_s;
    reg_rd && reg_addr == apgd_pkg::OFS_GINIT;
  endsequence

  sequence set_then_idle_s;
    (reg_wr && reg_addr == apgd_pkg::OFS_SET) ##1 !reg_wr;
  endsequence

  sequence clr_then_idle_s;
    (reg_wr && reg_addr == apgd_pkg::OFS_CLR) ##1 !reg_wr;
  endsequence

  sequence ctl_write_s;
    reg_wr && (reg_addr == apgd_pkg::OFS_FUNC || reg_addr == apgd_pkg::OFS_DIR);
  endsequence

  level_read_a: assert property (@(posedge clk) disable iff (srst)
    rd_level_s |=> (reg_rdata == ($past(pin_sync_q) & apgd_pkg::PIN_MASK)))
    else $error("level read does not show pin levels");

  level_map_a: assert property (@(posedge clk) disable iff (srst)
    rd_level_s |=> (reg_rdata[31:25] == $past(pin_sync_q[31:25]) && reg_rdata[15:0] == $past(pin_sync_q[15:0])))
    else $error("level bit mapping wrong");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |-> ((reg_rdata[24:16] == 9'h000) && (out_data_q[24:16] == 9'h000) && (pin_oe_q[24:16] == 9'h000)))
    else $error("reserved bits not zero");

  alias_read_a: assert property (@(posedge clk) disable iff (srst)
    rd_alias_s |=> (reg_rdata == 32'h00000000))
    else $error("alias read returned data");

  set_bits_a: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == apgd_pkg::OFS_SET)
      |=> (out_data_q == ($past(out_data_q) | ($past(reg_wdata) & apgd_pkg::PIN_MASK))))
    else $error("set alias did not set exactly its ones");

  clr_bits_a: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == apgd_pkg::OFS_CLR)
      |=> (out_data_q == ($past(out_data_q) & ~($past(reg_wdata) & apgd_pkg::PIN_MASK))))
    else $error("clear alias did not clear exactly its ones");

  set_pos_a: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == apgd_pkg::OFS_SET && reg_wdata == 32'h80000000)
      |=> (out_data_q[31] && out_data_q[30:0] == $past(out_data_q[30:0])))
    else $error("set bit 31 acted on wrong position");

  clr_pos_a: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == apgd_pkg::OFS_CLR && reg_wdata == 32'h02000000)
      |=> (!out_data_q[25] && out_data_q[31:26] == $past(out_data_q[31:26])))
    else $error("clear bit 25 acted on wrong position");

  drive_high_a: assert property (@(posedge clk) disable iff (srst)
    set_then_idle_s |=> ((pin_out_q & func_sel_q & dir_sel_q & $past(reg_wdata, 2) & apgd_pkg::PIN_MASK)
                         == (func_sel_q & dir_sel_q & $past(reg_wdata, 2) & apgd_pkg::PIN_MASK)))
    else $error("set pin not driven high");

  drive_low_a: assert property (@(posedge clk) disable iff (srst)
    clr_then_idle_s |=> ((pin_out_q & func_sel_q & dir_sel_q & $past(reg_wdata, 2)) == 32'h00000000))
    else $error("cleared pin not driven low");

  pin_gate_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> (pin_oe_q == ($past(dir_sel_q) & apgd_pkg::PIN_MASK)
              && ((pin_out_q ^ $past(out_data_q)) & $past(func_sel_q) & apgd_pkg::PIN_MASK) == 32'h00000000))
    else $error("pin drive does not follow select bits");

  out_keep_a: assert property (@(posedge clk) disable iff (srst)
    ctl_write_s |=> $stable(out_data_q))
    else $error("select write changed output data");

  ginit_read_a: assert property (@(posedge clk) disable iff (srst)
    rd_ginit_s |=> (reg_rdata[12:8] == $past(tx_lif.latched) && reg_rdata[4:0] == $past(rx_lif.latched)
                    && reg_rdata[31:13] == 19'h00000 && reg_rdata[7:5] == 3'h0))
    else $error("init readback is not the latched value");

  ginit_wait_a: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == apgd_pkg::OFS_GINIT) ##1 (!reg_wr && !pin_sync_q[apgd_pkg::TXCLK_BIT])[*2]
      |=> (tx_init == $past(tx_init, 2)))
    else $error("transmit half latched without its bit clock");
endmodule : apgd_gpio_top

// [rtl/apgd_latch_if.sv]
// Carrier between the register slave and a serial-clock latch
`timescale 1ns/1ps
interface apgd_latch_if #(
  parameter int unsigned W = 5
);
  logic         wr;        // One-cycle write of the requested value
  logic [W-1:0] wdata;     // Requested value
  logic         bclk;      // Synchronised bit clock level
  logic [W-1:0] latched;   // Value taken in on the bit clock

  modport ctl (output wr, output wdata, output bclk, input latched);
  modport lat (input wr, input wdata, input bclk, output latched);
endinterface : apgd_latch_if

// [rtl/apgd_pkg.sv]
// Shared constants for the audio port pin GPIO data block
package apgd_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W        = 8;            // Register address width
  localparam int unsigned DATA_W        = 32;           // Register data width
  localparam int unsigned CLK_PERIOD_PS = 8000;         // System clock period, 125 MHz

  // Register byte offsets
  localparam logic [7:0]  OFS_OUT       = 8'h00;        // Output-data register, read/write
  localparam logic [7:0]  OFS_FUNC      = 8'h04;        // Pin function select
  localparam logic [7:0]  OFS_DIR       = 8'h08;        // Pin direction select
  localparam logic [7:0]  OFS_LEVEL     = 8'h0C;        // Pin level input, read only
  localparam logic [7:0]  OFS_SET       = 8'h10;        // Write-1-to-set alias
  localparam logic [7:0]  OFS_CLR       = 8'h14;        // Write-1-to-clear alias
  localparam logic [7:0]  OFS_GINIT     = 8'h18;        // Global initialization register

  // Field layout of the pin registers
  localparam logic [31:0] PIN_MASK      = 32'hFE00FFFF; // Implemented pin bits
  localparam logic [31:0] PIN_RESET     = 32'h00000000; // Reset value of pin control words
  localparam int unsigned TXCLK_BIT     = 26;           // Transmit bit clock pin position
  localparam int unsigned RXCLK_BIT     = 29;           // Receive bit clock pin position

  // Field layout of the global initialization register
  localparam int unsigned INIT_W        = 5;            // Width of each half
  localparam int unsigned TX_INIT_LSB   = 8;            // Transmit half, bits 12-8
  localparam int unsigned RX_INIT_LSB   = 0;            // Receive half, bits 4-0
  localparam logic [4:0]  INIT_RESET    = 5'h00;        // Reset value of each half
endpackage : apgd_pkg
